// ---- hw/adc_conversion_sequencer.sv ----
// conversion sequencer with avalon register slave
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    // clock and reset
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic [31:0]      avs_readdata_out,
    output logic             avs_waitrequest_out,
    // analog core
    input  wire logic        alternate_clock_in,
    input  wire logic        hw_trigger_input_in,
    input  wire logic        core_done_in,
    input  wire logic [10:0] core_result_in,
    output logic             core_enable_out,
    output logic             core_start_out,
    output logic             async_clock_run_out,
    output logic             converter_clock_out,
    output logic             conv_irq_out,
    // pin control, channels 0..23
    output logic [23:0]      pin_output_tristate_out,
    output logic [23:0]      pin_pullup_off_out,
    output logic [23:0]      pin_input_buffer_off_out
);
    logic [7:0]  sc1_ff;
    logic [7:0]  sc2_ff;
    logic [7:0]  cfg_ff;
    logic [7:0]  cvh_ff;
    logic [7:0]  cvl_ff;
    logic [7:0]  res_high_ff;
    logic [7:0]  res_low_ff;
    logic [23:0] pin_disable_ff;
    logic        high_read_ff;
    logic        ack_ff;
    conv_state_e state_ff;
    logic        trig_meta_ff;
    logic        trig_sync_ff;
    logic        trig_prev_ff;
    logic [3:0]  div_cnt_ff;
    logic        bus_half_ff;
    logic        clk_src_ff;
    logic        clk_src_prev_ff;

    // decoded controls
    logic        wr;
    logic        rd;
    logic        ch_off;
    logic        mode10;
    logic        trig_edge;
    logic [9:0]  rounded;
    logic [9:0]  cmp_val;
    logic [9:0]  diff;
    logic        cmp_true;
    logic        blocked;
    logic        finish;
    logic        transfer;
    logic        sw_start;
    logic        abort;

    // a write or read is taken once; the ack cycle ends waitrequest
    assign wr = avs_write_in && !ack_ff;
    assign rd = avs_read_in && !ack_ff;
    assign ch_off = (sc1_ff[4:0] == `CH_OFF);
    assign mode10 = (cfg_ff[3:2] == 2'b10);

    // round half up, saturating at full scale
    function automatic logic [9:0] round_res(input logic [10:0] raw, input logic m10);
        logic [10:0] s;
        s = 11'h000;
        if (m10) begin
            s = (raw == 11'h7FF) ? 11'h7FF : raw + 11'h001;
            round_res = s[10:1];
        end else begin
            s = {2'b00, raw[8:0]};
            s = (s == 11'h1FF) ? s : s + 11'h001;
            round_res = {2'b00, s[8:1]};
        end
    endfunction

    assign rounded = round_res(core_result_in, mode10);
    assign cmp_val = mode10 ? {cvh_ff[1:0], cvl_ff} : {2'b00, cvl_ff};
    assign diff = rounded - cmp_val;
    assign cmp_true = !sc2_ff[`SC2_COMPARE_ENABLE] ||
                      (sc2_ff[`SC2_ACFGT] ? (rounded >= cmp_val) : (rounded < cmp_val));
    assign blocked = mode10 && high_read_ff;
    assign finish = (state_ff == ST_CONV) && core_done_in;
    // a result finishing beside an aborting or restarting write is dropped
    assign transfer = finish && cmp_true && !blocked && !abort && !sw_start;
    assign sw_start = wr && (avs_address_in == `OFS_SC1) &&
                      (avs_writedata_in[4:0] != `CH_OFF) && !sc2_ff[`SC2_HW_TRIGGER_ENABLE];
    assign abort = wr && ((avs_address_in == `OFS_SC2) || (avs_address_in == `OFS_CFG) ||
                          (avs_address_in == `OFS_CVH) || (avs_address_in == `OFS_CVL) ||
                          (avs_address_in == `OFS_SC1 && avs_writedata_in[4:0] == `CH_OFF));
    assign trig_edge = trig_sync_ff && !trig_prev_ff;

    // bus handshake: one wait cycle per access
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= (avs_read_in || avs_write_in) && !ack_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            avs_waitrequest_out <= 1'b1;
        end else begin
            avs_waitrequest_out <= !((avs_read_in || avs_write_in) && !ack_ff);
        end
    end

    // read data registered on the taking edge
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (rd) begin
            case (avs_address_in)
                `OFS_SC1:     avs_readdata_out <= {24'h00_0000, sc1_ff};
                `OFS_SC2:     avs_readdata_out <= {24'h00_0000, sc2_ff};
                `OFS_CFG:     avs_readdata_out <= {24'h00_0000, cfg_ff};
                `OFS_RESH:    avs_readdata_out <= {24'h00_0000, res_high_ff};
                `OFS_RESL:    avs_readdata_out <= {24'h00_0000, res_low_ff};
                `OFS_CVH:     avs_readdata_out <= {24'h00_0000, cvh_ff};
                `OFS_CVL:     avs_readdata_out <= {24'h00_0000, cvl_ff};
                `OFS_APD_LO:  avs_readdata_out <= {24'h00_0000, pin_disable_ff[7:0]};
                `OFS_APD_MID: avs_readdata_out <= {24'h00_0000, pin_disable_ff[15:8]};
                `OFS_APD_UP:  avs_readdata_out <= {24'h00_0000, pin_disable_ff[23:16]};
                `OFS_CORE:    avs_readdata_out <= {30'h0000_0000, state_ff};
                default:      avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // first status/control: flag set wins over software clear
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sc1_ff <= `SC1_RESET;
        end else begin
            if (wr && avs_address_in == `OFS_SC1) begin
                sc1_ff[6:0] <= avs_writedata_in[6:0];
            end
            if (transfer) begin
                sc1_ff[`SC1_CONV_COMPLETE_FLAG] <= 1'b1;
            end else if (wr && avs_address_in == `OFS_SC1) begin
                sc1_ff[`SC1_CONV_COMPLETE_FLAG] <= 1'b0;
            end else if (rd && avs_address_in == `OFS_RESL) begin
                sc1_ff[`SC1_CONV_COMPLETE_FLAG] <= 1'b0;
            end
        end
    end

    // second status/control: only trigger and compare bits are kept
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            sc2_ff <= 8'h00;
        end else if (wr && avs_address_in == `OFS_SC2) begin
            sc2_ff <= {1'b0, avs_writedata_in[6:4], 4'h0};
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cfg_ff <= `CFG_RESET;
        end else if (wr && avs_address_in == `OFS_CFG) begin
            cfg_ff <= avs_writedata_in[7:0];
        end
    end

    // compare value: only two bits above the low byte exist
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cvh_ff <= 8'h00;
        end else if (wr && avs_address_in == `OFS_CVH) begin
            cvh_ff <= {6'h00, avs_writedata_in[1:0]};
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            cvl_ff <= 8'h00;
        end else if (wr && avs_address_in == `OFS_CVL) begin
            cvl_ff <= avs_writedata_in[7:0];
        end
    end

    // pin disable bits
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pin_disable_ff <= 24'h00_0000;
        end else if (wr) begin
            if (avs_address_in == `OFS_APD_LO)  pin_disable_ff[7:0]   <= avs_writedata_in[7:0];
            if (avs_address_in == `OFS_APD_MID) pin_disable_ff[15:8]  <= avs_writedata_in[7:0];
            if (avs_address_in == `OFS_APD_UP)  pin_disable_ff[23:16] <= avs_writedata_in[7:0];
        end
    end

    // port read returns zero because the input buffer is off
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pin_output_tristate_out <= 24'h00_0000;
        end else begin
            pin_output_tristate_out <= pin_disable_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pin_pullup_off_out <= 24'h00_0000;
        end else begin
            pin_pullup_off_out <= pin_disable_ff;
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            pin_input_buffer_off_out <= 24'h00_0000;
        end else begin
            pin_input_buffer_off_out <= pin_disable_ff;
        end
    end

    // results; a transfer in compare mode stores the difference
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            res_high_ff <= 8'h00;
            res_low_ff  <= 8'h00;
        end else if (transfer) begin
            if (mode10) begin
                res_high_ff <= {6'h00, (sc2_ff[`SC2_COMPARE_ENABLE] ? diff[9:8] : rounded[9:8])};
                res_low_ff  <= sc2_ff[`SC2_COMPARE_ENABLE] ? diff[7:0] : rounded[7:0];
            end else begin
                res_high_ff <= 8'h00;
                res_low_ff  <= sc2_ff[`SC2_COMPARE_ENABLE] ? diff[7:0] : rounded[7:0];
            end
        end
    end

    // partial read tracking for blocking
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            high_read_ff <= 1'b0;
        end else if (rd && avs_address_in == `OFS_RESL) begin
            high_read_ff <= 1'b0;
        end else if (rd && avs_address_in == `OFS_RESH) begin
            high_read_ff <= 1'b1;
        end
    end

    // trigger synchroniser
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            trig_meta_ff <= 1'b0;
            trig_sync_ff <= 1'b0;
            trig_prev_ff <= 1'b0;
        end else begin
            trig_meta_ff <= hw_trigger_input_in;
            trig_sync_ff <= trig_meta_ff;
            trig_prev_ff <= trig_sync_ff;
        end
    end

    // sequencer: edges only seen when idle, so continuous runs ignore them
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            state_ff       <= ST_IDLE;
            core_start_out <= 1'b0;
        end else begin
            core_start_out <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (sw_start || (trig_edge && sc2_ff[`SC2_HW_TRIGGER_ENABLE] && !ch_off && !abort)) begin
                        state_ff       <= ST_CONV;
                        core_start_out <= 1'b1;
                    end
                end
                ST_CONV: begin
                    if (sw_start) begin
                        core_start_out <= 1'b1;
                    end else if (abort) begin
                        state_ff <= ST_IDLE;
                    end else if (finish) begin
                        if (transfer && sc1_ff[`SC1_CONTINUOUS_ENABLE]) begin
                            core_start_out <= 1'b1;
                        end else if (!transfer && blocked &&
                                     !(sc2_ff[`SC2_COMPARE_ENABLE] && !cmp_true && !sc1_ff[`SC1_CONTINUOUS_ENABLE])) begin
                            core_start_out <= 1'b1;
                        end else if (!transfer && !cmp_true && sc1_ff[`SC1_CONTINUOUS_ENABLE]) begin
                            core_start_out <= 1'b1;
                        end else begin
                            state_ff <= ST_IDLE;
                        end
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            core_enable_out <= 1'b0;
        end else begin
            core_enable_out <= (state_ff == ST_CONV) && !ch_off;
        end
    end

    // interrupt on enabled flag
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            conv_irq_out <= 1'b0;
        end else begin
            conv_irq_out <= sc1_ff[`SC1_CONV_COMPLETE_FLAG] && sc1_ff[`SC1_CONV_IRQ_ENABLE];
        end
    end

    // async clock runs while selected and converting
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            async_clock_run_out <= 1'b0;
        end else begin
            async_clock_run_out <= (clk_src_e'(cfg_ff[1:0]) == CLK_ASYNC) &&
                                   (state_ff == ST_CONV);
        end
    end

    // source mux: alt clock sampled as enable, async core-local
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            bus_half_ff     <= 1'b0;
            clk_src_ff      <= 1'b0;
            clk_src_prev_ff <= 1'b0;
        end else begin
            bus_half_ff     <= !bus_half_ff;
            clk_src_prev_ff <= clk_src_ff;
            case (clk_src_e'(cfg_ff[1:0]))
                CLK_BUS:     clk_src_ff <= !clk_src_ff;
                CLK_BUS_DV2: clk_src_ff <= bus_half_ff;
                CLK_ALT:     clk_src_ff <= alternate_clock_in;
                default:     clk_src_ff <= 1'b0;
            endcase
        end
    end

    // divider by 1,1,2,4 of the source; the counter steps on both source edges
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            div_cnt_ff          <= 4'h0;
            converter_clock_out <= 1'b0;
        end else if (clk_src_ff != clk_src_prev_ff) begin
            div_cnt_ff          <= div_cnt_ff + 4'h1;
            case (cfg_ff[6:5])
                2'b00:   converter_clock_out <= clk_src_ff;
                2'b01:   converter_clock_out <= div_cnt_ff[0];
                2'b10:   converter_clock_out <= div_cnt_ff[1];
                default: converter_clock_out <= div_cnt_ff[2];
            endcase
        end
    end
endmodule

// ---- inc/adc_seq_cfg.svh ----
// register offsets, field positions and reset values
// Behaviour
// - each upper disable bit frees pin 16-23
// - disabled pin: tristate, no pullup, reads zero
// - disabled in reset or channel all ones
// - idle lowest power after finishing
// - 10-bit: round 11-bit result, split high/low
// - 8-bit: round 9-bit result into low
// - result placed sets flag, irq if enabled
// - compare enable checks each result
// - four clock sources, bus clock after reset; code runs bus/2 at the same rate as bus
// - async clock kept running in low power; code runs it only while converting
// - divide selected clock by 1,2,4,8; code divides by 1,1,2,4
// - hw trigger rising edge starts conversion
// - edge ignored while converting
// - continuous plus hw: first edge only
// - mode field picks 10 or 8 bit
// - first register write starts conversion
// - continuous restarts after each transfer
// - complete at transfer; irq enable sampled then; code gates the flag with the live enable
// - high read, low unread: block transfer
// - single compare false: blocking ignored, stop
// - other blocked cases start another conversion
// - clock select encoding 00 bus..11 async
// - mode register writes abort, keep results
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH
`define OFS_SC1      4'h0
`define OFS_SC2      4'h1
`define OFS_CFG      4'h2
`define OFS_RESH     4'h3
`define OFS_RESL     4'h4
`define OFS_CVH      4'h5
`define OFS_CVL      4'h6
`define OFS_APD_LO   4'h7
`define OFS_APD_MID  4'h8
`define OFS_APD_UP   4'h9
`define OFS_CORE     4'hA
`define SC1_CONV_COMPLETE_FLAG     7
`define SC1_CONV_IRQ_ENABLE     6
`define SC1_CONTINUOUS_ENABLE     5
`define SC2_HW_TRIGGER_ENABLE    6
`define SC2_COMPARE_ENABLE     5
`define SC2_ACFGT    4
`define CH_OFF       5'h1F
`define SC1_RESET    8'h1F
`define CFG_RESET    8'h00
`endif

// ---- inc/adc_seq_pkg.sv ----
// types for the conversion sequencer
package adc_seq_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CONV = 2'b01
    } conv_state_e;
    typedef enum logic [1:0] {
        CLK_BUS     = 2'b00,
        CLK_BUS_DV2 = 2'b01,
        CLK_ALT     = 2'b10,
        CLK_ASYNC   = 2'b11
    } clk_src_e;
endpackage

// ---- testbench/adc_conversion_sequencer_checker.sv ----
// port assertions for the conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer_checker (
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic [3:0]  avs_address_in,
    input wire logic        avs_read_in,
    input wire logic        avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic        avs_waitrequest_out,
    input wire logic        core_done_in,
    input wire logic        core_enable_out,
    input wire logic        core_start_out,
    input wire logic        async_clock_run_out,
    input wire logic        conv_irq_out,
    input wire logic [23:0] pin_output_tristate_out,
    input wire logic [23:0] pin_pullup_off_out,
    input wire logic [23:0] pin_input_buffer_off_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);
    logic       ack;
    logic       sc1_wr;
    logic       hw_en_ff;
    logic [7:0] apd_up_ff;
    assign ack = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
    assign sc1_wr = ack && avs_write_in && (avs_address_in == `OFS_SC1);
    // shadow copies so starts and pin levels can be predicted
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            hw_en_ff  <= 1'b0;
            apd_up_ff <= 8'h00;
        end else if (ack && avs_write_in) begin
            if (avs_address_in == `OFS_SC2) hw_en_ff <= avs_writedata_in[`SC2_HW_TRIGGER_ENABLE];
            if (avs_address_in == `OFS_APD_UP) apd_up_ff <= avs_writedata_in[7:0];
        end
    end
    a_pin_ctl_agree: assert property (pin_output_tristate_out == pin_pullup_off_out
        && pin_output_tristate_out == pin_input_buffer_off_out) else $error("pin controls differ");
    a_pin_upper_follow: assert property (ack && avs_write_in
        && avs_address_in == `OFS_APD_UP
        |-> ##2 pin_output_tristate_out[23:16] == apd_up_ff) else $error("upper pins wrong");
    a_chan_off_stop: assert property (sc1_wr && avs_writedata_in[4:0] == `CH_OFF
        |-> ##1 !core_enable_out) else $error("converter enabled with channel off");
    a_sw_write_start: assert property (sc1_wr && !hw_en_ff
        && avs_writedata_in[4:0] != `CH_OFF
        |-> ##[0:3] core_start_out) else $error("software start missing");
    a_start_pulse_short: assert property (core_start_out |=> !core_start_out)
        else $error("start longer than one cycle");
    a_irq_after_done: assert property ($rose(conv_irq_out) |-> $past(core_done_in, 2))
        else $error("interrupt without completion");
    a_async_with_conv: assert property (async_clock_run_out |-> core_enable_out)
        else $error("async clock running while idle");
    a_irq_fall_cause: assert property ($fell(conv_irq_out) && !$past(reset_in)
        |-> ack || $past(ack) || $past(ack, 2)) else $error("interrupt dropped by itself");
    a_wait_one_low: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("waitrequest low too long");
    a_wait_answer: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |-> ##[0:2] !avs_waitrequest_out) else $error("no bus answer");
    a_read_upper_zero: assert property (ack && avs_read_in |-> avs_readdata_out[31:8] == 24'h00_0000)
        else $error("read data upper bits set");
    c_irq_rise: cover property ($rose(conv_irq_out));
    c_core_start: cover property (core_start_out);
    c_pins_off: cover property (pin_output_tristate_out[23:16] != 8'h00);
    c_async_run: cover property (async_clock_run_out);
endmodule
bind adc_conversion_sequencer adc_conversion_sequencer_checker u_checker (
    .clock_in(clock_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .core_done_in(core_done_in), .core_enable_out(core_enable_out),
    .core_start_out(core_start_out), .conv_irq_out(conv_irq_out),
    .async_clock_run_out(async_clock_run_out),
    .pin_output_tristate_out(pin_output_tristate_out), .pin_pullup_off_out(pin_pullup_off_out),
    .pin_input_buffer_off_out(pin_input_buffer_off_out));

// ---- testbench/adc_conversion_sequencer_tb_top.sv ----
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`include "adc_seq_cfg.svh"
module adc_conversion_sequencer_tb_top;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic [3:0]  avs_address_in = 4'h0;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        hw_trig = 1'b0;
    logic        core_done, core_enable, core_start, conv_irq;
    logic [10:0] core_result;
    logic [10:0] core_value = 11'h000;
    logic [23:0] pin_tri, pin_pull, pin_inbuf;
    logic [31:0] rd;
    int          failures = 0;
    int          num_checks = 0;
    int          starts = 0;
    int          s0;
    always #12.5 clock_in = ~clock_in;
    always @(posedge clock_in) if (core_start === 1'b1) starts <= starts + 1;
    adc_conversion_sequencer u_dut (
        .clock_in(clock_in), .reset_in(reset_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .alternate_clock_in(1'b0),
        .hw_trigger_input_in(hw_trig), .core_done_in(core_done), .core_result_in(core_result),
        .core_enable_out(core_enable), .core_start_out(core_start), .async_clock_run_out(),
        .converter_clock_out(), .conv_irq_out(conv_irq), .pin_output_tristate_out(pin_tri),
        .pin_pullup_off_out(pin_pull), .pin_input_buffer_off_out(pin_inbuf));
    adc_core_model u_core (
        .clock_in(clock_in), .reset_in(reset_in), .enable_in(core_enable),
        .start_in(core_start), .value_in(core_value), .done_out(core_done),
        .result_out(core_result));
    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // request held until the edge that samples waitrequest low
    task automatic bus_cycle(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avs_address_in <= a;
        avs_writedata_in <= {24'h00_0000, d};
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge clock_in);
        end while (avs_waitrequest_out !== 1'b0);
        rd = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        @(posedge clock_in);
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus_cycle(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        bus_cycle(1'b0, a, 8'h00);
        check(rd, {24'h00_0000, e});
    endtask
    task automatic wait_irq(input logic e);
        int n;
        n = 0;
        while (conv_irq !== e && n < 200) begin
            @(posedge clock_in);
            n++;
        end
        check({31'h0000_0000, conv_irq}, {31'h0000_0000, e});
    endtask
    task automatic convert(input logic [7:0] cfg, input logic [10:0] v, input logic [7:0] eh, el);
        core_value <= v;
        wr(`OFS_CFG, cfg);
        wr(`OFS_SC1, 8'h43);
        wait_irq(1'b1);
        rd_chk(`OFS_SC1, 8'hC3);
        if (cfg[3]) rd_chk(`OFS_RESH, eh);
        rd_chk(`OFS_RESL, el);
        wait_irq(1'b0);
        rd_chk(`OFS_CORE, 8'h00);
    endtask
    task automatic pulse();
        hw_trig <= 1'b1;
        repeat (3) @(posedge clock_in);
        hw_trig <= 1'b0;
        repeat (3) @(posedge clock_in);
    endtask
    initial begin
        repeat (20000) @(posedge clock_in);
        failures++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clock_in);
        reset_in <= 1'b0;
        @(posedge clock_in);
        rd_chk(`OFS_SC1, 8'h1F);
        rd_chk(`OFS_CFG, 8'h00);
        rd_chk(`OFS_APD_UP, 8'h00);
        wr(4'hB, 8'h55);
        rd_chk(4'hB, 8'h00);
        wr(`OFS_APD_UP, 8'hA5);
        rd_chk(`OFS_APD_UP, 8'hA5);
        check({8'h00, pin_tri}, 32'h00A5_0000);
        check({pin_pull, pin_inbuf[23:16]}, 32'hA500_00A5);
        convert(8'h08, 11'h2A5, 8'h01, 8'h53);
        convert(8'h08, 11'h7FF, 8'h03, 8'hFF);
        convert(8'h00, 11'h0FF, 8'h00, 8'h80);
        convert(8'h03, 11'h1FF, 8'h00, 8'hFF);
        // early high read in 10-bit mode keeps discarding results
        core_value <= 11'h100;
        wr(`OFS_CFG, 8'h08);
        s0 = starts;
        wr(`OFS_SC1, 8'h43);
        bus_cycle(1'b0, `OFS_RESH, 8'h00);
        repeat (70) @(posedge clock_in);
        check({31'h0000_0000, conv_irq}, 32'h0000_0000);
        check({31'h0000_0000, (starts - s0) >= 2}, 32'h0000_0001);
        bus_cycle(1'b0, `OFS_RESL, 8'h00);
        wait_irq(1'b1);
        rd_chk(`OFS_RESH, 8'h00);
        rd_chk(`OFS_RESL, 8'h80);
        // compare against 0x10, greater-or-equal, set before converting
        wr(`OFS_CVH, 8'h00);
        wr(`OFS_CVL, 8'h10);
        wr(`OFS_SC2, 8'h30);
        convert(8'h00, 11'h041, 8'h00, 8'h11);
        core_value <= 11'h00F;
        wr(`OFS_SC1, 8'h43);
        repeat (60) @(posedge clock_in);
        check({31'h0000_0000, conv_irq}, 32'h0000_0000);
        rd_chk(`OFS_CORE, 8'h00);
        rd_chk(`OFS_RESL, 8'h11);
        // hardware trigger: write alone must not start
        wr(`OFS_SC2, 8'h40);
        s0 = starts;
        wr(`OFS_SC1, 8'h43);
        repeat (5) @(posedge clock_in);
        check(starts - s0, 32'h0000_0000);
        pulse();
        pulse();
        wait_irq(1'b1);
        check(starts - s0, 32'h0000_0001);
        rd_chk(`OFS_RESL, 8'h08);
        // continuous series launched by one edge, then aborted
        wr(`OFS_SC1, 8'h23);
        s0 = starts;
        pulse();
        repeat (100) @(posedge clock_in);
        check({31'h0000_0000, (starts - s0) >= 3}, 32'h0000_0001);
        // a new input level would show if the series were not aborted
        core_value <= 11'h0FF;
        wr(`OFS_SC2, 8'h00);
        s0 = starts;
        repeat (40) @(posedge clock_in);
        check({31'h0000_0000, core_enable}, 32'h0000_0000);
        check(starts - s0, 32'h0000_0000);
        rd_chk(`OFS_RESL, 8'h08);
        wr(`OFS_SC1, 8'h1F);
        check({31'h0000_0000, core_enable}, 32'h0000_0000);
        report_and_stop();
    end
endmodule

// ---- testbench/adc_core_model.sv ----
// behavioural analog approximation core
`timescale 1ns/1ps
module adc_core_model #(
    parameter int DELAY = 20
) (
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        enable_in,
    input  wire logic        start_in,
    input  wire logic [10:0] value_in,
    output logic             done_out,
    output logic [10:0]      result_out
);
    int count_ff;
    always @(posedge clock_in) begin
        done_out <= 1'b0;
        if (reset_in) begin
            count_ff <= 0;
        end else if (start_in) begin
            count_ff <= DELAY;
        end else if (!enable_in) begin
            count_ff <= 0;
        end else if (count_ff > 0) begin
            count_ff <= count_ff - 1;
            done_out <= (count_ff == 1);
        end
    end
    // result only valid with done, so a late sample shows garbage
    assign result_out = done_out ? value_in : ~value_in;
endmodule
